// ---- sim/touch_adc_config_register_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsacr_regs.svh"

module touch_adc_config_register_bench;
  logic ref_clk, rst, pen_touch, cs_n, sclk, sdi, sdo, sdo_en;
  logic adc_power_down, panel_drive_en, adc_sample_en, conv_done;
  logic pen_or_data_ready_out, seen;
  logic [11:0] adc_data;
  logic [15:0] conv_result;
  int failures, comparisons, samp_n, conv_n, setl_n, done_n, en_n;

  tsacr_top u_dut (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_en(sdo_en),
    .pen_touch(pen_touch), .adc_data(adc_data),
    .adc_power_down(adc_power_down), .panel_drive_en(panel_drive_en),
    .adc_sample_en(adc_sample_en), .conv_result(conv_result),
    .conv_done(conv_done),
    .pen_or_data_ready_out(pen_or_data_ready_out));
  tsacr_host u_host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk),
    .sdi(sdi), .sdo(sdo));

  // ****************************************
  // clock, counters and helpers
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // phase length counters
  always @(posedge ref_clk) begin
    if (adc_sample_en) samp_n <= samp_n + 1;
    if (adc_sample_en) seen <= 1'b1;
    if (panel_drive_en && !adc_sample_en && seen) conv_n <= conv_n + 1;
    if (panel_drive_en && !adc_sample_en && !seen) setl_n <= setl_n + 1;
    if (conv_done) done_n <= done_n + 1;
    if (sdo_en) en_n <= en_n + 1;
  end

  task automatic clr;
    samp_n = 0;
    conv_n = 0;
    setl_n = 0;
    done_n = 0;
    seen = 1'b0;
  endtask : clr

  task automatic check(input string what, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wait_done(input int lim);
    for (int k = 0; k < lim && done_n == 0; k++) u_host.tick(1);
    check("conv_done", done_n > 0, 1);
  endtask : wait_done

  task automatic wait_idle;
    logic [15:0] v;
    v = 16'h0000;
    for (int k = 0; k < 30 && v[14] !== 1'b1; k++)
      u_host.rd(`TSACR_ADDR_CFG, v);
    check("idle", v[14], 1'b1);
  endtask : wait_idle

  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    logic [15:0] v;
    u_host.rd(`TSACR_ADDR_CFG, v);
    check("cfg reset", v, `TSACR_CFG_RD_IDLE);
    check("pd reset", adc_power_down, 1'b0);
    pen_touch = 1'b1;
    u_host.wr(`TSACR_ADDR_CFG, 16'h2a55);
    u_host.wr(4'h8, 16'hffff);
    u_host.rd(`TSACR_ADDR_CFG, v);
    check("cfg back", v, 16'hea55);
    u_host.rd(4'h5, v);
    check("unmapped", v, 16'h0000);
    check("sdo_en", en_n, 3 * 16 * 8);
    pen_touch = 1'b0;
    $display("test regs done");
  endtask : t_regs

  task automatic t_conv(input logic rm, input logic [1:0] cl,
                        input logic long_sample_mode, input logic [2:0] pv,
                        input logic [11:0] ad);
    logic [15:0] v;
    int nb, dv, per;
    nb = rm ? 12 : 10;
    // code 11 as /4, /1 at 12 bits as /2
    dv = (cl == 2'h3) ? 2 : (cl == 2'h0 && rm) ? 1 : cl;
    per = `TSACR_OSC_CYC << dv;
    adc_data = ad;
    u_host.wr(`TSACR_ADDR_CFG, {3'h0, cl, pv, 7'h00, long_sample_mode});
    clr();
    u_host.start(4'h2, {rm, 2'h0});
    u_host.rd(`TSACR_ADDR_CFG, v);
    check("cfg busy", v, {2'h0, rm, cl, pv, 7'h00, long_sample_mode});
    wait_done(4000);
    check("sample", samp_n, `TSACR_SAMPLE_OSC * `TSACR_OSC_CYC
      + (long_sample_mode ? `TSACR_LSM_CYC : 0));
    check("convert", conv_n, nb * per);
    if (pv != 3'h0)
      check("settle", setl_n >= 2500 && setl_n <= 2502, 1);
    check("ready", pen_or_data_ready_out, 1'b1);
    check("hi zero", conv_result >> nb, 0);
    u_host.rd(`TSACR_ADDR_RESULT, v);
    if (rm) check("result", v, {4'h0, adc_data});
    else check("result", v, {6'h00, adc_data[11:2]});
    check("rd zero", v >> nb, 0);
    check("ready clr", pen_or_data_ready_out, 1'b0);
    wait_idle();
    $display("test conv done");
  endtask : t_conv

  task automatic t_stop;
    u_host.wr(`TSACR_ADDR_CFG, 16'h0200);
    clr();
    u_host.start(4'h2, 3'h0);
    u_host.tick(100);
    check("driving", panel_drive_en, 1'b1);
    u_host.wr(`TSACR_ADDR_CFG, 16'h4200);
    u_host.tick(3);
    check("abort", panel_drive_en, 1'b0);
    check("pd on", adc_power_down, 1'b1);
    u_host.tick(1000);
    check("no done", done_n, 0);
    u_host.wr(`TSACR_ADDR_CFG, 16'h0000);
    u_host.tick(3);
    check("pd off", adc_power_down, 1'b0);
    $display("test stop done");
  endtask : t_stop

  task automatic t_self;
    u_host.wr(`TSACR_ADDR_CFG, 16'h8000);
    clr();
    pen_touch = 1'b1;
    wait_done(3000);
    pen_touch = 1'b0;
    wait_idle();
    u_host.tick(200);
    check("self ends", panel_drive_en, 1'b0);
    u_host.wr(`TSACR_ADDR_CFG, 16'h0000);
    $display("test self done");
  endtask : t_self

  task automatic t_dtw;
    u_host.wr(`TSACR_ADDR_CFG, 16'h0002);
    clr();
    u_host.tick(3);
    check("no pen", pen_or_data_ready_out, 1'b1);
    // host skips the start while line high
    if (pen_or_data_ready_out !== 1'b1) u_host.start(4'h2, 3'h0);
    u_host.tick(500);
    check("skipped", done_n, 0);
    pen_touch = 1'b1;
    u_host.tick(3);
    check("pen", pen_or_data_ready_out, 1'b0);
    pen_touch = 1'b0;
    $display("test dtw done");
  endtask : t_dtw

  task automatic t_reset;
    logic [15:0] v;
    u_host.wr(`TSACR_ADDR_CFG, 16'h2a57);
    rst = 1'b1;
    u_host.tick(3);
    check("rst result", conv_result, 16'h0000);
    check("rst ready", pen_or_data_ready_out, 1'b0);
    rst = 1'b0;
    u_host.rd(`TSACR_ADDR_CFG, v);
    check("cfg rst", v, `TSACR_CFG_RD_IDLE);
    check("sdo_en idle", sdo_en, 1'b0);
    $display("test reset done");
  endtask : t_reset

  // main sequence
  initial begin
    rst = 1'b1;
    pen_touch = 1'b0;
    adc_data = 12'hdb7;
    failures = 0;
    comparisons = 0;
    clr();
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_regs();
    t_conv(1'b0, 2'h0, 1'b0, 3'h0, 12'hdb7);
    t_conv(1'b1, 2'h1, 1'b1, 3'h0, 12'h5a3);
    t_conv(1'b0, 2'h2, 1'b0, 3'h1, 12'h3c9);
    t_conv(1'b1, 2'h3, 1'b0, 3'h0, 12'h801);
    t_conv(1'b1, 2'h0, 1'b0, 3'h0, 12'hfff);
    t_stop();
    t_self();
    t_dtw();
    t_reset();
    summarize();
  end

  // watchdog
  initial begin
    repeat (90000) @(posedge ref_clk);
    failures++;
    $display("Error watchdog expected end seen hang");
    summarize();
  end
endmodule : touch_adc_config_register_bench

`default_nettype wire

// ---- sim/tsacr_host.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// spi host model
// ****************************************
module tsacr_host (
  // clock
  input wire logic ref_clk,
  // serial port
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  // idle bus at time zero
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // wait edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // one frame msb first, sdo taken before each data rise
  // command byte, then one word when n is 24
  task automatic xfer(input logic [23:0] bits, input int n,
                      output logic [15:0] rd);
    rd = 16'h0000;
    tick(1);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = bits[23 - i];
      tick(4);
      if (i >= 8) rd = {rd[14:0], sdo};
      sclk = 1'b1;
      tick(4);
      sclk = 1'b0;
    end
    tick(4);
    cs_n = 1'b1;
    sdi = ~sdi; // released line shows no stale bit
  endtask : xfer

  // register write, address plus write bit
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] x;
    xfer({1'b0, a, 3'h0, d}, 24, x);
  endtask : wr

  // register read, address plus read bit
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    xfer({1'b0, a, 3'h1, 16'h0000}, 24, d);
  endtask : rd

  // start byte, no word follows
  task automatic start(input logic [3:0] f, input logic [2:0] c);
    logic [15:0] x;
    xfer({1'b1, f, c, 16'h0000}, 8, x);
  endtask : start
endmodule : tsacr_host

`default_nettype wire

// ---- src/tsacr_delay_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsacr_regs.svh"

module tsacr_delay_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic abort,
  input wire logic [16:0] load_us,
  // completion
  output logic done
);

  tsacr_pkg::tsacr_tmr_st_t st;
  tsacr_pkg::tsacr_tmr_st_t nx;

  // microsecond countdown, done pulse at zero
  always_comb begin
    nx = st;
    nx.done = 1'b0;
    if (abort) begin
      nx.run = 1'b0;
    end else if (load) begin
      nx.cnt = load_us;
      nx.pre = 5'h00;
      nx.run = 1'b1;
    end else if (st.run) begin
      if (st.cnt == 17'h00000) begin
        nx.run = 1'b0;
        nx.done = 1'b1;
      end else if (st.pre == `TSACR_US_CYC - 5'h01) begin
        nx.pre = 5'h00;
        nx.cnt = st.cnt - 17'h00001;
      end else begin
        nx.pre = st.pre + 5'h01;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign done = st.done;

endmodule : tsacr_delay_timer
`default_nettype wire

// ---- src/tsacr_pkg.sv ----
package tsacr_pkg;

  // sequencer phases
  typedef enum logic [2:0] {
    SQ_IDLE, SQ_SETTLE, SQ_SAMPLE, SQ_CONV, SQ_PRECH, SQ_SENSE
  } tsacr_seq_t;

  // delay timer state
  typedef struct packed {
    logic [4:0] pre;
    logic [16:0] cnt;
    logic run;
    logic done;
  } tsacr_tmr_st_t;

  // top state
  typedef struct packed {
    logic sclk_d;
    logic [4:0] bit_cnt;
    logic in_data;
    logic [7:0] cmd;
    logic [15:0] sh_in;
    logic [15:0] sh_out;
    logic [15:0] cfg;
    logic swrst;
    tsacr_seq_t seq;
    logic [1:0] coords;
    logic auto_run;
    logic [9:0] cyc;
    logic [3:0] bits_left;
    logic [15:0] result;
    logic data_rdy;
    logic conv_pulse;
    logic pint;
  } tsacr_top_st_t;

endpackage : tsacr_pkg

// ---- src/tsacr_regs.svh ----
`ifndef TSACR_REGS_SVH
`define TSACR_REGS_SVH

// ****************************************
// register addresses and reset values
// ****************************************
`define TSACR_ADDR_RESULT 4'h0
`define TSACR_ADDR_CFG 4'hc
`define TSACR_CFG_WR_RST 16'h0000
`define TSACR_CFG_RD_IDLE 16'h4000

// ****************************************
// configuration field positions
// ****************************************
`define TSACR_B_PSM 15
`define TSACR_B_STS 14
`define TSACR_B_RM 13
`define TSACR_F_CL 12:11
`define TSACR_F_PV 10:8
`define TSACR_F_PR 7:5
`define TSACR_F_SN 4:2
`define TSACR_B_DTW 1
`define TSACR_B_LSM 0

// ****************************************
// command byte fields
// ****************************************
`define TSACR_CB_ID 7
`define TSACR_CB_ADDR 6:3
`define TSACR_CB_RW 0
`define TSACR_CB1_RM 2
`define TSACR_CB1_RST 1
`define TSACR_CB1_STS 0
`define TSACR_C_XYZ 4'h0
`define TSACR_C_XY 4'h1
`define TSACR_C_RESV 4'hc
`define TSACR_CMD_LAST 5'h07
`define TSACR_WORD_LAST 5'h0f

// ****************************************
// timing
// ****************************************
`define TSACR_CLK_NS 40
`define TSACR_US_NS 1000
`define TSACR_US_CYC 5'((`TSACR_US_NS + `TSACR_CLK_NS - 1) / `TSACR_CLK_NS)
`define TSACR_LSM_NS 500
`define TSACR_LSM_CYC 10'((`TSACR_LSM_NS + `TSACR_CLK_NS - 1) / `TSACR_CLK_NS)
`define TSACR_OSC_NS 250
`define TSACR_OSC_CYC 10'(`TSACR_OSC_NS / `TSACR_CLK_NS)
`define TSACR_SAMPLE_OSC 10'h003
`define TSACR_BITS_LO 4'ha
`define TSACR_BITS_HI 4'hc
`define TSACR_DIV_1 2'h0
`define TSACR_DIV_2 2'h1
`define TSACR_DIV_4 2'h2
// tables in microseconds, code 7 first
`define TSACR_PV_TBL {17'd100000, 17'd50000, 17'd10000, 17'd5000, \
  17'd1000, 17'd500, 17'd100, 17'd0}
`define TSACR_PR_TBL {17'd1364, 17'd1300, 17'd1108, 17'd1044, \
  17'd340, 17'd276, 17'd84, 17'd20}
`define TSACR_SN_TBL {17'd2656, 17'd2592, 17'd2144, 17'd2080, \
  17'd608, 17'd544, 17'd96, 17'd32}

`endif

// ---- src/tsacr_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsacr_regs.svh"

module tsacr_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial port
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_en,
  // analog front end
  input wire logic pen_touch,
  input wire logic [11:0] adc_data,
  output logic adc_power_down,
  output logic panel_drive_en,
  output logic adc_sample_en,
  // results
  output logic [15:0] conv_result,
  output logic conv_done,
  output logic pen_or_data_ready_out
);

  tsacr_pkg::tsacr_top_st_t st, nx;
  logic tmr_load, tmr_abort, tmr_done;
  logic [16:0] tmr_us;
  logic stop, idle, rise, fall, start_host;
  logic [7:0] cmd_byte;
  logic [15:0] word_in, cfg_rd;
  logic [1:0] eff_div;
  logic [9:0] conv_period;

  // ****************************************
  // derived status
  // ****************************************
  assign stop = st.cfg[`TSACR_B_STS] | st.swrst;
  assign idle = (st.seq == tsacr_pkg::SQ_IDLE);
  assign rise = sclk & ~st.sclk_d;
  assign fall = ~sclk & st.sclk_d;
  assign cmd_byte = {st.sh_in[6:0], sdi};
  assign word_in = {st.sh_in[14:0], sdi};

  // read image of the configuration word
  // pen status read
  always_comb begin
    cfg_rd = st.cfg;
    cfg_rd[`TSACR_B_PSM] = pen_touch;
    cfg_rd[`TSACR_B_STS] = idle;
  end

  // converter clock divide, unsafe codes remapped
  // divider select
  always_comb begin
    eff_div = st.cfg[`TSACR_F_CL];
    if (eff_div == 2'h3) begin
      eff_div = `TSACR_DIV_4;
    end else if (eff_div == `TSACR_DIV_1 && st.cfg[`TSACR_B_RM]) begin
      eff_div = `TSACR_DIV_2;
    end
    conv_period = `TSACR_OSC_CYC << eff_div;
  end

  // ****************************************
  // serial command decoder and sequencer
  // ****************************************
  always_comb begin
    nx = st;
    nx.sclk_d = sclk;
    nx.conv_pulse = 1'b0;
    tmr_load = 1'b0;
    tmr_abort = 1'b0;
    tmr_us = 17'h00000;
    start_host = 1'b0;
    if (cs_n) begin
      nx.bit_cnt = 5'h00;
      nx.in_data = 1'b0;
    end else begin
      // shift out read word after its first data edge
      if (fall && st.in_data && st.bit_cnt != 5'h00) begin
        nx.sh_out = {st.sh_out[14:0], 1'b0};
      end
      if (rise) begin
        nx.sh_in = word_in;
        nx.bit_cnt = st.bit_cnt + 5'h01;
        if (!st.in_data && st.bit_cnt == `TSACR_CMD_LAST) begin
          nx.bit_cnt = 5'h00;
          nx.cmd = cmd_byte;
          if (cmd_byte[`TSACR_CB_ID]) begin
            nx.cfg[`TSACR_B_RM] = cmd_byte[`TSACR_CB1_RM];
            nx.cfg[`TSACR_B_STS] = cmd_byte[`TSACR_CB1_STS];
            nx.swrst = cmd_byte[`TSACR_CB1_RST];
            start_host = !cmd_byte[`TSACR_CB1_STS] &&
              !cmd_byte[`TSACR_CB1_RST] &&
              cmd_byte[`TSACR_CB_ADDR] < `TSACR_C_RESV;
            nx.coords = (cmd_byte[`TSACR_CB_ADDR] == `TSACR_C_XYZ) ? 2'h3 :
              (cmd_byte[`TSACR_CB_ADDR] == `TSACR_C_XY) ? 2'h2 : 2'h1;
          end else begin
            nx.in_data = 1'b1;
            nx.sh_out = 16'h0000;
            if (cmd_byte[`TSACR_CB_RW]) begin
              if (cmd_byte[`TSACR_CB_ADDR] == `TSACR_ADDR_CFG) begin
                nx.sh_out = cfg_rd;
              end else if (cmd_byte[`TSACR_CB_ADDR] == `TSACR_ADDR_RESULT) begin
                nx.sh_out = st.result;
                nx.data_rdy = 1'b0;
              end
            end
          end
        end else if (st.in_data && st.bit_cnt == `TSACR_WORD_LAST) begin
          nx.bit_cnt = 5'h00;
          nx.in_data = 1'b0;
          // written state held apart from read image
          if (!st.cmd[`TSACR_CB_RW] &&
              st.cmd[`TSACR_CB_ADDR] == `TSACR_ADDR_CFG) begin
            nx.cfg = word_in;
          end
        end
      end
    end
    if (nx.swrst) begin
      nx.cfg = `TSACR_CFG_WR_RST;
    end
    // conversion sequence
    case (st.seq)
      tsacr_pkg::SQ_IDLE: begin
        if (!stop && (start_host ||
            (st.cfg[`TSACR_B_PSM] && pen_touch))) begin
          nx.auto_run = !start_host;
          if (!start_host) begin
            nx.coords = 2'h3;
          end
          nx.seq = tsacr_pkg::SQ_SETTLE;
          tmr_load = 1'b1;
          tmr_us = `TSACR_PV_TBL[st.cfg[`TSACR_F_PV] * 17 +: 17];
        end
      end
      tsacr_pkg::SQ_SETTLE: begin
        if (tmr_done) begin
          nx.seq = tsacr_pkg::SQ_SAMPLE;
          nx.cyc = `TSACR_SAMPLE_OSC * `TSACR_OSC_CYC +
            (st.cfg[`TSACR_B_LSM] ? `TSACR_LSM_CYC : 10'h000);
        end
      end
      tsacr_pkg::SQ_SAMPLE: begin
        // last count ends the phase, so the load value is its length
        if (st.cyc == 10'h001) begin
          nx.seq = tsacr_pkg::SQ_CONV;
          nx.cyc = conv_period;
          nx.bits_left = st.cfg[`TSACR_B_RM] ? `TSACR_BITS_HI
            : `TSACR_BITS_LO;
        end else begin
          nx.cyc = st.cyc - 10'h001;
        end
      end
      tsacr_pkg::SQ_CONV: begin
        if (st.cyc > 10'h001) begin
          nx.cyc = st.cyc - 10'h001;
        end else if (st.bits_left > 4'h1) begin
          nx.cyc = conv_period;
          nx.bits_left = st.bits_left - 4'h1;
        end else begin
          nx.result = st.cfg[`TSACR_B_RM] ? {4'h0, adc_data}
            : {6'h00, adc_data[11:2]};
          nx.data_rdy = 1'b1;
          nx.conv_pulse = 1'b1;
          nx.seq = tsacr_pkg::SQ_PRECH;
          tmr_load = 1'b1;
          tmr_us = `TSACR_PR_TBL[st.cfg[`TSACR_F_PR] * 17 +: 17];
        end
      end
      tsacr_pkg::SQ_PRECH: begin
        if (tmr_done) begin
          nx.seq = tsacr_pkg::SQ_SENSE;
          tmr_load = 1'b1;
          tmr_us = `TSACR_SN_TBL[st.cfg[`TSACR_F_SN] * 17 +: 17];
        end
      end
      tsacr_pkg::SQ_SENSE: begin
        if (tmr_done) begin
          if (st.auto_run && !pen_touch) begin
            nx.seq = tsacr_pkg::SQ_IDLE;
          end else if (st.coords > 2'h1) begin
            nx.coords = st.coords - 2'h1;
            nx.seq = tsacr_pkg::SQ_SETTLE;
            tmr_load = 1'b1;
            tmr_us = `TSACR_PV_TBL[st.cfg[`TSACR_F_PV] * 17 +: 17];
          end else begin
            nx.seq = tsacr_pkg::SQ_IDLE;
          end
        end
      end
      default: begin
        nx.seq = tsacr_pkg::SQ_IDLE;
      end
    endcase

    if (stop) begin
      nx.seq = tsacr_pkg::SQ_IDLE;
      tmr_abort = 1'b1;
    end

    if (!st.cfg[`TSACR_B_PSM] && st.cfg[`TSACR_B_DTW] &&
        nx.seq == tsacr_pkg::SQ_IDLE) begin
      nx.pint = !pen_touch;
    end else begin
      nx.pint = nx.data_rdy;
    end
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  // stage delays
  tsacr_delay_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(tmr_load),
    .abort(tmr_abort),
    .load_us(tmr_us),
    .done(tmr_done)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign sdo = st.sh_out[15];
  assign sdo_en = !cs_n && st.in_data && st.cmd[`TSACR_CB_RW];
  assign adc_power_down = stop;
  assign panel_drive_en = (st.seq == tsacr_pkg::SQ_SETTLE) ||
    (st.seq == tsacr_pkg::SQ_SAMPLE) || (st.seq == tsacr_pkg::SQ_CONV);
  assign adc_sample_en = (st.seq == tsacr_pkg::SQ_SAMPLE);
  assign conv_result = st.result;
  assign conv_done = st.conv_pulse;
  assign pen_or_data_ready_out = st.pint;

  // ****************************************
  // checks
  // ****************************************
  AST_RESET_VALUE: assert property (@(posedge ref_clk)
    $fell(rst) |-> (st.cfg == `TSACR_CFG_WR_RST) &&
      ((cfg_rd | 16'h8000) == (`TSACR_CFG_RD_IDLE | 16'h8000)))
    else $error("config reset value wrong");
  AST_PEN_READ: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_rd[`TSACR_B_PSM] == pen_touch)
    else $error("pen bit mismatch");
  AST_IDLE_READ: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_rd[`TSACR_B_STS] == (st.seq == tsacr_pkg::SQ_IDLE))
    else $error("idle bit mismatch");
  AST_STOP_ABORT: assert property (@(posedge ref_clk) disable iff (rst)
    stop |-> adc_power_down ##1 st.seq == tsacr_pkg::SQ_IDLE)
    else $error("stop did not abort");
  AST_AUTO_START: assert property (@(posedge ref_clk) disable iff (rst)
    (idle && !stop && st.cfg[`TSACR_B_PSM] && pen_touch)
      |=> st.seq == tsacr_pkg::SQ_SETTLE)
    else $error("self-run scan not started");
  AST_RES_BITS: assert property (@(posedge ref_clk) disable iff (rst)
    (st.seq == tsacr_pkg::SQ_SAMPLE && st.cyc == 10'h001 && !stop)
      |=> st.bits_left == (st.cfg[`TSACR_B_RM] ? 4'hc : 4'ha))
    else $error("wrong resolution bit count");
  AST_LONG_SAMPLE: assert property (@(posedge ref_clk) disable iff (rst)
    (st.seq == tsacr_pkg::SQ_SETTLE && tmr_done && !stop)
      |=> st.cyc == (st.cfg[`TSACR_B_LSM] ? 10'd31 : 10'd18))
    else $error("sample length wrong");
  AST_NO_FAST_12: assert property (@(posedge ref_clk) disable iff (rst)
    st.cfg[`TSACR_B_RM] |-> conv_period >= 10'd12)
    else $error("12-bit run at 4MHz");
  AST_BG_DETECT: assert property (@(posedge ref_clk) disable iff (rst)
    (!st.cfg[`TSACR_B_PSM] && st.cfg[`TSACR_B_DTW] && idle && !pen_touch &&
      nx.seq == tsacr_pkg::SQ_IDLE) |=> pen_or_data_ready_out)
    else $error("background detect line low");
  AST_RIGHT_ALIGN: assert property (@(posedge ref_clk) disable iff (rst)
    conv_done |-> conv_result[15:12] == 4'h0 &&
      ($past(st.cfg[`TSACR_B_RM]) || conv_result[11:10] == 2'h0))
    else $error("result not right aligned");
endmodule : tsacr_top
`default_nettype wire
